// >>> snp_host_model.sv
// Model of up to four remote hosts: take-ready, jam, connect and probe reply.
// Assumes the core clock and the bench's control levels drive it.
`timescale 1ns/10ps
`default_nettype none

module snp_host_model #(
    parameter int NS = 4
) (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic mute,
    input wire logic [NS-1:0] jam_set,
    input wire logic [NS-1:0] want,
    input wire logic [NS-1:0] sess_open,
    input wire logic [NS-1:0] sess_probe,
    output logic [NS-1:0] sess_rdy,
    output logic [NS-1:0] sess_jam,
    output logic [NS-1:0] sess_req,
    output logic [NS-1:0] sess_act,
    output logic [NS-1:0] sess_fin
);
    // A jammed host never takes a byte; a slow one takes bytes at random
    always @(posedge core_clk) begin
        sess_rdy <= ~jam_set & (slow ? NS'($urandom) : {NS{1'b1}});
        sess_act <= mute ? '0 : sess_probe;
    end
    // Requests stand until granted; hosts never hang up on their own
    assign sess_req = want & ~sess_open;
    assign sess_jam = jam_set;
    assign sess_fin = '0;
endmodule

`default_nettype wire

// >>> snp_pkg.sv
// Constants, register map and types of the serial-to-network packetizer.
// Assumes a single 250 MHz core clock and an APB register port.

package snp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PACK = 8'h00;
    localparam logic [7:0] OFS_DLM = 8'h04;
    localparam logic [7:0] OFS_FTX = 8'h08;
    localparam logic [7:0] OFS_INACT = 8'h0C;
    localparam logic [7:0] OFS_ALIVE = 8'h10;
    localparam logic [7:0] OFS_SESS = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_FRMS = 8'h1C;
    // Field positions
    localparam int DLM_D1_LSB = 0;
    localparam int DLM_D2_LSB = 8;
    localparam int DLM_EN1_BIT = 16;
    localparam int DLM_EN2_BIT = 17;
    localparam int DLM_PROC_LSB = 18;
    localparam int SESS_MAX_LSB = 0;
    localparam int SESS_SKIP_BIT = 4;
    localparam int SESS_DRV_BIT = 5;
    localparam int STAT_OPEN_LSB = 11;
    localparam int STAT_BUSY_BIT = 15;
    // Reset values
    localparam logic [10:0] RST_PACK = 11'h000;
    localparam logic [15:0] RST_FTX = 16'h0000;
    localparam logic [15:0] RST_INACT = 16'h0000;
    localparam logic [6:0] RST_ALIVE = 7'h07;
    localparam logic [2:0] RST_MAXC = 3'h1;
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] MIN_MS = 16'hEA60;
    localparam logic [15:0] KA_PERIOD_MS = 16'h03E8;
    localparam logic [15:0] KA_WAIT_MS = 16'h0064;
    localparam int BUF_BYTES = 1024;

    typedef enum logic [1:0] {
        ST_FILL = 2'b00,
        ST_LOAD = 2'b01,
        ST_SEND = 2'b11
    } snp_st_t;

    typedef enum logic [1:0] {
        DP_NONE = 2'b00,
        DP_PLUS1 = 2'b01,
        DP_PLUS2 = 2'b10,
        DP_STRIP = 2'b11
    } snp_dp_t;
endpackage

// >>> snp_tb_top.sv
// Self-checking bench of the packetizer: set-up, frame triggers, sessions.
// Assumes snp_pkg, snp_top and snp_host_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module snp_tb_top import snp_pkg::*;;
    localparam int MSC = 10;
    localparam int LIM = 20000;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_valid = 1'b0;
    logic [7:0] paddr = 8'h00, rx_data = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, rx_ready, out_valid, out_last, ctl_stb;
    logic [7:0] out_data;
    logic [3:0] sess_rdy, sess_jam, sess_tx_en, sess_req, sess_act, sess_fin;
    logic [3:0] sess_open, sess_drop, sess_probe;
    logic [3:0] jam_set = 4'h0, want = 4'h0;
    logic slow = 1'b0, mute = 1'b0, cmd_valid = 1'b0;
    logic [15:0] cmd_data = 16'h0000;
    logic [15:0] ctl_cmd;
    logic net_valid = 1'b0, ser_ready = 1'b1, net_ready, ser_valid;
    logic [7:0] net_data = 8'h00, ser_data, nb;
    logic [7:0] ofs[6] = '{OFS_PACK, OFS_DLM, OFS_FTX, OFS_INACT, OFS_ALIVE, OFS_SESS};
    logic [3:0] rv[6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h7, 4'h1};
    logic [8:0] expq[$];
    logic [7:0] txq[$];
    logic [7:0] netq[$];
    int err_total = 0, samples_checked = 0, stbs = 0, probes = 0, n;

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    snp_top #(.MS_CYC(MSC), .NS(4)) dut_u (
        .core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rx_valid, .rx_data, .rx_ready, .out_valid, .out_data, .out_last,
        .sess_rdy, .sess_jam, .sess_tx_en, .net_valid, .net_data, .net_ready, .ser_valid,
        .ser_data, .ser_ready, .sess_req, .sess_act,
        .sess_fin, .sess_open, .sess_drop, .sess_probe, .cmd_valid, .cmd_data, .ctl_cmd,
        .ctl_stb
    );
    snp_host_model #(.NS(4)) host_u (
        .core_clk, .slow, .mute, .jam_set, .want, .sess_open, .sess_probe, .sess_rdy,
        .sess_jam, .sess_req, .sess_act, .sess_fin
    );

    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s is %h not %h", $time, what, seen, exp);
        end
    endtask

    // A wait that used up its bound counts as a fault and ends the run
    task automatic guard();
        if (n >= LIM) begin
            err_total++;
            give_verdict();
        end
    endtask

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Wait states end at the edge that sees pready; data is taken there
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < LIM);
        guard();
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Queue bytes (zero means random 0x20 to 0x7F) and note those expected out
    task automatic add(input int cnt, input logic [7:0] b, input logic keep);
        logic [7:0] v;
        repeat (cnt) begin
            v = (b != 8'h00) ? b : 8'h20 + 8'($urandom % 96);
            txq.push_back(v);
            if (keep) expq.push_back({1'b0, v});
        end
    endtask

    // Serial source holds each byte until taken; lowers valid only at the end
    task automatic send(input logic fin);
        if (fin) expq[expq.size()-1][8] = 1'b1;
        foreach (txq[i]) begin
            rx_valid <= 1'b1;
            rx_data <= txq[i];
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (rx_ready !== 1'b1 && n < LIM);
            guard();
            @(posedge core_clk);
        end
        rx_valid <= 1'b0;
        txq = {};
    endtask

    task automatic drain();
        n = 0;
        while ((expq.size() != 0 || netq.size() != 0) && n < LIM) begin
            @(posedge core_clk);
            n++;
        end
        guard();
    endtask

    task automatic wait_drop();
        rdata = 32'h0000_0000;
        n = 0;
        do begin
            @(negedge core_clk);
            rdata = rdata | 32'(sess_drop);
            n++;
        end while (rdata == 32'h0000_0000 && n < LIM);
        guard();
        // Each host keeps its own probe phase; give the later one a full round
        repeat (12000) begin
            @(negedge core_clk);
            rdata = rdata | 32'(sess_drop);
        end
        @(posedge core_clk);
    endtask

    task automatic cmd(input logic [15:0] v);
        cmd_valid <= 1'b1;
        cmd_data <= v;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // A byte is taken when every host owed it is ready; compare oldest note
    always @(negedge core_clk) begin
        if (ctl_stb === 1'b1) stbs++;
        if (sess_probe !== 4'h0) probes++;
        if (out_valid === 1'b1 && &(sess_rdy | ~sess_tx_en)) begin
            if (expq.size() == 0) chk(1'b1, 1'b0, "byte beyond frame");
            else chk({out_last, out_data}, expq.pop_front(), "frame byte");
        end
        if (ser_valid === 1'b1 && ser_ready === 1'b1) begin
            chk(ser_data, netq.size() ? netq.pop_front() : 9'h100, "network byte");
        end
    end

    // The serial side takes network bytes at random moments
    always @(posedge core_clk) begin
        ser_ready <= 1'($urandom);
    end

    initial begin
        void'($urandom(32'hde04_0e47));
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0000_0000);
            chk(rdata, rv[i], "reset value");
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(rerr, 1'b1, "unmapped error");
        apb(1'b1, OFS_PACK, 32'h0000_0004);
        add(4, 8'h00, 1'b1);
        send(1'b1);
        drain();
        apb(1'b1, OFS_PACK, 32'h0000_0000);
        // Every processing option with delimiter one alone
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, OFS_DLM, 32'h0001_000D | (32'(p) << 18));
            add(3, 8'h00, 1'b1);
            add(1, 8'h0D, p != 3);
            add(p % 3, 8'h00, 1'b1);
            send(1'b1);
            drain();
        end
        // A lone first delimiter must not flush while the pair is armed
        apb(1'b1, OFS_DLM, 32'h0003_0A0D);
        add(1, 8'h0D, 1'b1);
        add(1, 8'h00, 1'b1);
        add(1, 8'h0D, 1'b1);
        add(1, 8'h0A, 1'b1);
        send(1'b1);
        drain();
        apb(1'b1, OFS_DLM, 32'h0000_0000);
        // Bytes come back to back, far inside one timeout interval
        apb(1'b1, OFS_FTX, 32'h0000_0003);
        add(2, 8'h00, 1'b1);
        send(1'b1);
        repeat (MSC) @(negedge core_clk);
        chk(out_valid, 1'b0, "early timeout flush");
        drain();
        apb(1'b1, OFS_FTX, 32'h0000_0000);
        add(1000, 8'h00, 1'b1);
        send(1'b0);
        repeat (200) @(negedge core_clk);
        chk(out_valid, 1'b0, "flush with no trigger");
        @(posedge core_clk);
        add(24, 8'h00, 1'b1);
        send(1'b1);
        drain();
        // Sessions: one by default, then two; the jammed one stalls sends until skipped
        want <= 4'h3;
        repeat (5) @(negedge core_clk);
        chk(sess_open, 4'h1, "open sessions");
        @(posedge core_clk);
        apb(1'b1, OFS_SESS, 32'h0000_0002);
        apb(1'b1, OFS_PACK, 32'h0000_0004);
        slow <= 1'b1;
        jam_set <= 4'h2;
        add(4, 8'h00, 1'b1);
        send(1'b1);
        repeat (100) @(negedge core_clk);
        chk(sess_tx_en & {4{out_valid}}, 4'h3, "stalled copy");
        @(posedge core_clk);
        apb(1'b1, OFS_SESS, 32'h0000_0012);
        drain();
        apb(1'b0, OFS_FRMS, 32'h0000_0000);
        chk(rdata, 32'h0000_0009, "frame count");
        jam_set <= 4'h0;
        cmd(16'h1234);
        chk(stbs, 0, "ignored command");
        apb(1'b1, OFS_SESS, 32'h0000_0032);
        cmd(16'h1234);
        cmd(16'hA5C3);
        chk({stbs[15:0], ctl_cmd}, 32'h0002_A5C3, "latest command");
        // Network bytes leave on the serial side in arrival order
        repeat (6) begin
            nb = 8'($urandom);
            netq.push_back(nb);
            net_valid <= 1'b1;
            net_data <= nb;
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (net_ready !== 1'b1 && n < LIM);
            guard();
            @(posedge core_clk);
        end
        net_valid <= 1'b0;
        drain();
        mute <= 1'b1;
        wait_drop();
        chk(rdata, 32'h0000_0003, "probe unanswered");
        chk(probes > 0, 1'b1, "probe sent");
        mute <= 1'b0;
        // Inactivity limit stays above the force-transmit timeout, now off
        apb(1'b1, OFS_INACT, 32'h0000_0005);
        wait_drop();
        chk(rdata, 32'h0000_0003, "inactivity close");
        give_verdict();
    end
endmodule

`default_nettype wire

// >>> snp_top.sv
// Serial-to-network packetizer: frame buffer, flush triggers, sessions.
// Assumes serial and network sides are logic on core_clk; APB slave.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module snp_top import snp_pkg::*; #(
    parameter int MS_CYC = MS_CYCLES,
    parameter int NS = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic [NS-1:0] sess_rdy,
    input wire logic [NS-1:0] sess_jam,
    output logic [NS-1:0] sess_tx_en,
    input wire logic net_valid,
    input wire logic [7:0] net_data,
    output logic net_ready,
    output logic ser_valid,
    output logic [7:0] ser_data,
    input wire logic ser_ready,
    input wire logic [NS-1:0] sess_req,
    input wire logic [NS-1:0] sess_act,
    input wire logic [NS-1:0] sess_fin,
    output logic [NS-1:0] sess_open,
    output logic [NS-1:0] sess_drop,
    output logic [NS-1:0] sess_probe,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_data,
    output logic [15:0] ctl_cmd,
    output logic ctl_stb
);
    logic rs1_r, rst_sb;
    logic [10:0] pack_r;
    logic [7:0] d1_r, d2_r;
    logic en1_r, en2_r, skip_r, drv_r;
    snp_dp_t proc_r;
    logic [15:0] ftx_r, inact_r, frms_r;
    logic [6:0] alive_r;
    logic [2:0] maxc_r;
    logic [31:0] rd_nxt;
    logic err_nxt;
    snp_st_t st_r;
    logic [7:0] mem [BUF_BYTES];
    logic [10:0] cnt_r, cnt_nxt, len_r;
    logic [9:0] rd_r;
    logic dm_r;
    logic [1:0] pend_r;
    logic [15:0] ftx_cnt_r, inact_cnt_r, min_cnt_r;
    logic [31:0] tick_r;
    logic ms_tick, min_tick;
    logic rx_fire, dly_ev, strip_ev, store, flush, ftx_hit, len_hit, full_hit;
    logic out_ready, send_done, ser_fire, inact_close;
    logic [2:0] open_cnt;
    logic [NS-1:0] grant;

    // Reset leaves through two flops so release is synchronous
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_r <= 1'b0;
            rst_sb <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_sb <= rs1_r;
        end
    end

    // APB writes take effect at the access edge
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            pack_r <= RST_PACK;
            {d1_r, d2_r, en1_r, en2_r} <= 18'h0_0000;
            proc_r <= DP_NONE;
            ftx_r <= RST_FTX;
            inact_r <= RST_INACT;
            alive_r <= RST_ALIVE;
            maxc_r <= RST_MAXC;
            {skip_r, drv_r} <= 2'b00;
        end else if (psel && penable && pwrite) begin
            if (paddr == OFS_PACK) begin
                pack_r <= pwdata[10:0];
            end else if (paddr == OFS_DLM) begin
                d1_r <= pwdata[DLM_D1_LSB+:8];
                d2_r <= pwdata[DLM_D2_LSB+:8];
                en1_r <= pwdata[DLM_EN1_BIT];
                en2_r <= pwdata[DLM_EN2_BIT];
                proc_r <= snp_dp_t'(pwdata[DLM_PROC_LSB+:2]);
            end else if (paddr == OFS_FTX) begin
                ftx_r <= pwdata[15:0];
            end else if (paddr == OFS_INACT) begin
                inact_r <= pwdata[15:0];
            end else if (paddr == OFS_ALIVE) begin
                alive_r <= pwdata[6:0];
            end else if (paddr == OFS_SESS) begin
                maxc_r <= pwdata[SESS_MAX_LSB+:3];
                skip_r <= pwdata[SESS_SKIP_BIT];
                drv_r <= pwdata[SESS_DRV_BIT];
            end
        end
    end

    // Read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == OFS_PACK) begin
            rd_nxt[10:0] = pack_r;
        end else if (paddr == OFS_DLM) begin
            rd_nxt[19:0] = {proc_r, en2_r, en1_r, d2_r, d1_r};
        end else if (paddr == OFS_FTX) begin
            rd_nxt[15:0] = ftx_r;
        end else if (paddr == OFS_INACT) begin
            rd_nxt[15:0] = inact_r;
        end else if (paddr == OFS_ALIVE) begin
            rd_nxt[6:0] = alive_r;
        end else if (paddr == OFS_SESS) begin
            rd_nxt[5:0] = {drv_r, skip_r, 1'b0, maxc_r};
        end else if (paddr == OFS_STAT) begin
            rd_nxt[10:0] = cnt_r;
            rd_nxt[STAT_OPEN_LSB+:4] = 4'(sess_open);
            rd_nxt[STAT_BUSY_BIT] = (st_r != ST_FILL);
        end else if (paddr == OFS_FRMS) begin
            rd_nxt[15:0] = frms_r;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // Read data is caught in the setup cycle, so it is steady when taken
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= err_nxt;
        end
    end
    assign pready = 1'b1;

    // Millisecond and minute ticks feed every timer
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            tick_r <= 32'h0000_0000;
            min_cnt_r <= 16'h0000;
        end else begin
            tick_r <= ms_tick ? 32'h0000_0000 : tick_r + 32'h0000_0001;
            if (min_tick) begin
                min_cnt_r <= 16'h0000;
            end else if (ms_tick) begin
                min_cnt_r <= min_cnt_r + 16'h0001;
            end
        end
    end
    assign ms_tick = (tick_r == 32'(MS_CYC - 1));
    assign min_tick = ms_tick && (min_cnt_r == MIN_MS - 16'h0001);

    // Flush triggers; the buffer refuses bytes while a frame drains
    assign rx_ready = (st_r == ST_FILL);
    assign rx_fire = rx_valid && rx_ready;
    // A lone second delimiter never matches; delimiter one is required
    assign dly_ev = rx_fire && en1_r && (en2_r ? (dm_r && rx_data == d2_r)
                                              : (rx_data == d1_r));
    assign strip_ev = dly_ev && (proc_r == DP_STRIP);
    assign store = rx_fire && !strip_ev;
    assign len_hit = (pack_r != 11'h000) && (cnt_r + 11'h001 >= pack_r);
    assign full_hit = (cnt_r == 11'(BUF_BYTES - 1));
    assign ftx_hit = (ftx_r != 16'h0000) && (cnt_r != 11'h000)
                     && (ftx_cnt_r >= ftx_r);
    assign flush = (st_r == ST_FILL) && (ftx_hit || (rx_fire && (len_hit || full_hit
                   || (pend_r == 2'h1) || (dly_ev && (proc_r == DP_NONE || strip_ev)))));
    // Stripping a pair also drops the first delimiter already stored
    always_comb begin
        cnt_nxt = cnt_r + {10'h000, store};
        if (strip_ev && en2_r && cnt_r != 11'h000) begin
            cnt_nxt = cnt_r - 11'h001;
        end
    end

    // Byte store; no reset needed on the data array
    always_ff @(posedge core_clk) begin
        if (store) begin
            mem[cnt_r[9:0]] <= rx_data;
        end
    end

    // Fill state: count, match state, pending bytes and interval timer
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            cnt_r <= 11'h000;
            dm_r <= 1'b0;
            pend_r <= 2'h0;
            ftx_cnt_r <= 16'h0000;
            len_r <= 11'h000;
        end else if (flush) begin
            len_r <= cnt_nxt;
            cnt_r <= 11'h000;
            dm_r <= 1'b0;
            pend_r <= 2'h0;
            ftx_cnt_r <= 16'h0000;
        end else if (st_r == ST_FILL) begin
            cnt_r <= cnt_nxt;
            if (rx_fire) begin
                dm_r <= en2_r && (rx_data == d1_r);
            end
            if (dly_ev && pend_r == 2'h0 && proc_r == DP_PLUS1) begin
                pend_r <= 2'h1;
            end else if (dly_ev && pend_r == 2'h0 && proc_r == DP_PLUS2) begin
                pend_r <= 2'h2;
            end else if (rx_fire && pend_r != 2'h0) begin
                pend_r <= pend_r - 2'h1;
            end
            if (cnt_r == 11'h000) begin
                ftx_cnt_r <= 16'h0000;
            end else if (ms_tick && ftx_cnt_r != 16'hFFFF) begin
                ftx_cnt_r <= ftx_cnt_r + 16'h0001;
            end
        end
    end

    // Every open host must take a byte unless skipping drops jammed ones
    assign sess_tx_en = sess_open & ~(skip_r ? sess_jam : '0);
    assign out_ready = &(sess_rdy | ~sess_tx_en);
    assign out_valid = (st_r == ST_SEND);
    assign send_done = out_valid && out_ready && out_last;

    // Drain: one cycle to read the array, one to offer the byte
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            st_r <= ST_FILL;
            rd_r <= 10'h000;
            out_data <= 8'h00;
            out_last <= 1'b0;
            frms_r <= 16'h0000;
        end else begin
            case (st_r)
                ST_FILL: begin
                    rd_r <= 10'h000;
                    if (flush && cnt_nxt != 11'h000) begin
                        st_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    out_data <= mem[rd_r];
                    out_last <= ({1'b0, rd_r} == len_r - 11'h001);
                    st_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (out_ready) begin
                        rd_r <= rd_r + 10'h001;
                        st_r <= out_last ? ST_FILL : ST_LOAD;
                        frms_r <= frms_r + {15'h0000, out_last};
                    end
                end
                default: st_r <= ST_FILL;
            endcase
        end
    end

    // Network bytes go to the serial port one at a time, in arrival order
    assign net_ready = !ser_valid || ser_ready;
    assign ser_fire = ser_valid && ser_ready;
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            ser_valid <= 1'b0;
            ser_data <= 8'h00;
        end else if (net_ready) begin
            ser_valid <= net_valid;
            ser_data <= net_data;
        end
    end

    // Driver commands: gated when several sessions are allowed
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            ctl_cmd <= 16'h0000;
            ctl_stb <= 1'b0;
        end else begin
            ctl_stb <= cmd_valid && (maxc_r <= 3'h1 || drv_r);
            if (cmd_valid && (maxc_r <= 3'h1 || drv_r)) begin
                ctl_cmd <= cmd_data;
            end
        end
    end

    // Serial idleness timer shared by all sessions
    always_ff @(posedge core_clk or negedge rst_sb) begin
        if (!rst_sb) begin
            inact_cnt_r <= 16'h0000;
        end else if (rx_fire || ser_fire || sess_open == '0) begin
            inact_cnt_r <= 16'h0000;
        end else if (ms_tick && inact_cnt_r != 16'hFFFF) begin
            inact_cnt_r <= inact_cnt_r + 16'h0001;
        end
    end
    assign inact_close = (inact_r != 16'h0000) && (inact_cnt_r >= inact_r);

    // Accept the lowest pending request while below the session limit
    always_comb begin
        open_cnt = 3'h0;
        grant = '0;
        for (int i = 0; i < NS; i++) begin
            open_cnt = open_cnt + {2'b00, sess_open[i]};
        end
        for (int i = 0; i < NS; i++) begin
            if (sess_req[i] && !sess_open[i] && grant == '0 && open_cnt < maxc_r) begin
                grant[i] = 1'b1;
            end
        end
    end

    // Per-session alive timer, keep-alive probing and close
    for (genvar g = 0; g < NS; g++) begin : g_sess
        logic [6:0] alv_r;
        logic [15:0] ka_r;
        logic kw_r, cls;
        assign cls = sess_open[g] && (sess_fin[g] || inact_close
                     || (alive_r != 7'h00 && alv_r >= alive_r)
                     || (kw_r && ka_r >= KA_WAIT_MS));
        always_ff @(posedge core_clk or negedge rst_sb) begin
            if (!rst_sb) begin
                sess_open[g] <= 1'b0;
                sess_drop[g] <= 1'b0;
                sess_probe[g] <= 1'b0;
                alv_r <= 7'h00;
                ka_r <= 16'h0000;
                kw_r <= 1'b0;
            end else begin
                sess_drop[g] <= cls;
                sess_probe[g] <= 1'b0;
                if (cls || !sess_open[g]) begin
                    sess_open[g] <= grant[g];
                    alv_r <= 7'h00;
                    ka_r <= 16'h0000;
                    kw_r <= 1'b0;
                end else begin
                    if (sess_act[g]) begin
                        alv_r <= 7'h00;
                    end else if (min_tick && alv_r != 7'h7F) begin
                        alv_r <= alv_r + 7'h01;
                    end
                    if (inact_r != 16'h0000 || (kw_r && sess_act[g])) begin
                        ka_r <= 16'h0000;
                        kw_r <= 1'b0;
                    end else if (!kw_r && ka_r >= KA_PERIOD_MS) begin
                        sess_probe[g] <= 1'b1;
                        kw_r <= 1'b1;
                        ka_r <= 16'h0000;
                    end else if (ms_tick) begin
                        ka_r <= ka_r + 16'h0001;
                    end
                end
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_sb);

    len_flush_a: assert property (rx_fire && len_hit |=> st_r != ST_FILL || len_r == 0)
        else $error("length trigger did not flush");
    len_off_a: assert property (pack_r == 11'h000 |-> !len_hit)
        else $error("length trigger active at zero");
    delim_now_a: assert property (dly_ev && proc_r == DP_NONE |=> st_r == ST_LOAD)
        else $error("delimiter did not flush");
    full_flush_a: assert property (rx_fire && full_hit |=> cnt_r == 11'h000)
        else $error("full buffer not flushed");
    plus_wait_a: assert property (dly_ev && proc_r == DP_PLUS2 && !len_hit && !full_hit
        && !ftx_hit && pend_r == 2'h0 |=> st_r == ST_FILL && pend_r == 2'h2)
        else $error("plus-two flushed early");
    strip_len_a: assert property (strip_ev && !en2_r |=> len_r == $past(cnt_r))
        else $error("stripped frame length wrong");
    ftx_off_a: assert property (ftx_r == 16'h0000 |-> !ftx_hit)
        else $error("timeout trigger active at zero");
    frame_clear_a: assert property (flush |=> cnt_r == 0 && !dm_r && ftx_cnt_r == 0)
        else $error("state not cleared after flush");
    drv_gate_a: assert property (cmd_valid && maxc_r > 3'h1 && !drv_r |=> !ctl_stb)
        else $error("driver command not discarded");
    sess_lim_a: assert property (open_cnt <= maxc_r || $past(open_cnt) > maxc_r)
        else $error("session limit exceeded");

    delim_c: cover property (dly_ev ##1 st_r == ST_LOAD);
    timeout_c: cover property (ftx_hit);
    multi_c: cover property (send_done && open_cnt > 3'h1);
endmodule

`default_nettype wire
